// ---- src/cdd_discovery_ctrl.sv ----
// cdd_discovery_ctrl: detector retry loop, trace notice and payment polling
// assumes an RF layer on pclk answering commands, and a host message framer
module cdd_discovery_ctrl #(
  parameter int TICK_CYCLES = cdd_pkg::RETRY_UNIT_CYCLES,
  parameter logic [7:0] COLLISION_STATUS = 8'h01,
  parameter logic [7:0] ACT_FAIL_STATUS = 8'h02,
  parameter logic [7:0] LINK_LOSS_REASON = 8'h03
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic meas_valid,
  input wire logic [15:0] meas_value,
  input wire logic [15:0] ref_value,
  output logic rf_cmd_valid,
  output cdd_pkg::cdd_op_e rf_cmd_op,
  output logic [1:0] rf_cmd_tech,
  input wire logic rf_cmd_ready,
  input wire logic rf_rsp_valid,
  input wire cdd_pkg::cdd_rsp_e rf_rsp,
  input wire logic rf_link_err,
  input wire logic host_deact_req,
  output logic ntf_valid,
  output cdd_pkg::cdd_ntf_e ntf_kind,
  output logic [3:0] ntf_gid,
  output logic [7:0] ntf_oid,
  output logic [7:0] ntf_status,
  output logic [31:0] ntf_payload,
  input wire logic ntf_ready
);
  import cdd_pkg::*;
  typedef struct packed {
    cdd_state_e st;
    cdd_state_e ret;
    cdd_phase_e ph;
    logic [1:0] tech;
    logic [7:0] retries;
    logic det_en;
    logic trace_en;
    logic [2:0] tech_en;
    logic [7:0] profile;
    logic [7:0] rperiod;
    logic [7:0] rcount;
    logic [7:0] dperiod;
    logic [15:0] thresh;
    logic cmd_valid;
    cdd_op_e op;
    logic [1:0] ctech;
    logic ntf_valid;
    cdd_ntf_e kind;
    logic [3:0] gid;
    logic [7:0] oid;
    logic [7:0] nstat;
    logic [31:0] payload;
    logic [31:0] prdata;
    logic slverr;
    logic tmr_start;
    logic [7:0] tmr_units;
  } cdd_core_s;
  cdd_core_s s;
  cdd_core_s next_s;
  logic tmr_done;

  // lowest enabled technology at or above from, as {found, tech}
  function automatic logic [2:0] first_en(input logic [2:0] mask,
                                          input logic [1:0] from);
    first_en = 3'h0;
    for (int i = 2; i >= 0; i--) begin
      if (mask[i] && (2'(i) >= from)) begin
        first_en = {1'b1, 2'(i)};
      end
    end
  endfunction : first_en

  // ============================================================
  // period timer shared by detector pulses and detection cycles
  cdd_tick_timer #(.TICK_CYCLES(TICK_CYCLES)) u_timer (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .start(s.tmr_start),
    .units(s.tmr_units),
    .done(tmr_done)
  );

  // ============================================================
  // next state: register file, discovery sequencer, notification queue
  always_comb begin
    logic go;
    logic pay;
    logic trig;
    logic send;
    logic [2:0] nxt;
    logic [2:0] mask;
    logic [15:0] refv;
    logic [15:0] diff;
    cdd_ntf_e skind;
    logic [7:0] sstat;
    logic [31:0] spay;
    next_s = s;
    go = 1'b0;
    send = 1'b0;
    skind = NTF_NONE;
    sstat = 8'h00;
    spay = 32'h00000000;
    next_s.tmr_start = 1'b0;
    pay = (s.profile == PAY_PROFILE);
    // payment polling uses only A and B
    mask = pay ? {1'b0, s.tech_en[1:0]} : s.tech_en;
    refv = {1'b0, ref_value[14:0]};
    diff = (meas_value >= refv) ? meas_value - refv : refv - meas_value;
    trig = (diff > s.thresh);
    nxt = first_en(mask, s.tech + 2'h1);
    // read data is captured in setup so the access phase needs no wait
    if (psel && !penable) begin
      next_s.prdata = 32'h00000000;
      next_s.slverr = 1'b0;
      case (paddr)
        OFS_CTRL: begin
          next_s.prdata[CTRL_DET] = s.det_en;
          next_s.prdata[CTRL_TRACE] = s.trace_en;
          next_s.prdata[CTRL_TECH +: 3] = s.tech_en;
        end
        OFS_PROFILE: next_s.prdata[7:0] = s.profile;
        OFS_RETRY: begin
          next_s.prdata[RETRY_PERIOD_LSB +: 8] = s.rperiod;
          next_s.prdata[RETRY_COUNT_LSB +: 8] = s.rcount;
        end
        OFS_DISC: next_s.prdata[7:0] = s.dperiod;
        OFS_THRESH: next_s.prdata[15:0] = s.thresh;
        OFS_STATUS: begin
          next_s.prdata[STAT_STATE_LSB +: 4] = s.st;
          next_s.prdata[STAT_RETRY_LSB +: 8] = s.retries;
          next_s.prdata[STAT_CMD] = s.cmd_valid;
          next_s.prdata[STAT_NTF] = s.ntf_valid;
        end
        default: next_s.slverr = 1'b1;
      endcase
    end
    // writes take effect at the access edge only
    if (psel && penable && pwrite) begin
      case (paddr)
        OFS_CTRL: begin
          go = pwdata[CTRL_START];
          next_s.det_en = pwdata[CTRL_DET];
          next_s.trace_en = pwdata[CTRL_TRACE];
          next_s.tech_en = pwdata[CTRL_TECH +: 3];
        end
        OFS_PROFILE: next_s.profile = pwdata[7:0];
        OFS_RETRY: begin
          next_s.rperiod = pwdata[RETRY_PERIOD_LSB +: 8];
          next_s.rcount = pwdata[RETRY_COUNT_LSB +: 8];
        end
        OFS_DISC: next_s.dperiod = pwdata[7:0];
        OFS_THRESH: next_s.thresh = pwdata[15:0];
        default: ;
      endcase
    end
    // discovery sequencer
    unique case (s.st)
      ST_IDLE: if (go) next_s.st = s.det_en ? ST_LP_WAIT : ST_TD_START;
      ST_LP_WAIT: if (tmr_done) begin
        next_s.ph = PH_PULSE;
        next_s.st = ST_CMD;
      end
      ST_MEAS: if (meas_valid) begin
        if (trig) begin
          next_s.retries = s.rcount;
          next_s.st = ST_TD_START;
        end else begin
          next_s.st = ST_LP_WAIT;
        end
        if (s.trace_en) begin
          send = 1'b1;
          skind = NTF_TRACE;
          spay = {meas_value, refv};
        end
      end
      ST_TD_START: begin
        nxt = first_en(mask, 2'h0);
        next_s.st = nxt[2] ? ST_CMD : ST_END;
        next_s.ph = PH_WUP;
        next_s.tech = nxt[1:0];
      end
      ST_CMD: if (rf_cmd_ready) begin
        next_s.cmd_valid = 1'b0;
        next_s.st = (s.ph == PH_PULSE) ? ST_MEAS :
                    (s.ph == PH_OFF) ? ST_TD_START : ST_RSP;
      end
      ST_RSP: if (rf_rsp_valid) begin
        next_s.st = ST_CMD;
        unique case (s.ph)
          PH_WUP: begin
            if (rf_rsp == RSP_CARD || (rf_rsp == RSP_COLL && !pay)) begin
              next_s.ph = PH_ACT;
            end else if (rf_rsp == RSP_COLL) begin
              send = 1'b1;
              skind = NTF_GEN_ERR;
              sstat = COLLISION_STATUS;
              next_s.st = ST_END;
            end else if (nxt[2]) begin
              next_s.tech = nxt[1:0];
            end else begin
              next_s.st = ST_END;
            end
          end
          PH_ACT: next_s.ph = pay ? PH_HALT : PH_ISODEP;
          PH_HALT: next_s.ph = PH_OTHER;
          PH_OTHER: begin
            next_s.ph = PH_REACT;
            if (rf_rsp != RSP_NONE) begin
              send = 1'b1;
              skind = NTF_GEN_ERR;
              sstat = COLLISION_STATUS;
              next_s.st = ST_END;
            end
          end
          PH_REACT: next_s.ph = PH_ISODEP;
          PH_ISODEP: if (rf_rsp == RSP_OK) begin
            send = 1'b1;
            skind = NTF_INTF_ACT;
            next_s.st = ST_ACTIVE;
          end
          default: next_s.st = ST_END;
        endcase
        // a failed activation step of a single card
        if (rf_rsp != RSP_OK && (s.ph == PH_ACT || s.ph == PH_REACT ||
            s.ph == PH_ISODEP)) begin
          send = 1'b1;
          skind = NTF_GEN_ERR;
          sstat = ACT_FAIL_STATUS;
          next_s.st = ST_END;
        end
      end
      ST_END: begin
        next_s.st = ST_TD_WAIT;
        if (s.det_en && s.retries == 8'h00) begin
          next_s.st = ST_LP_WAIT;
        end else if (s.det_en) begin
          next_s.retries = s.retries - 8'h01;
        end
      end
      ST_TD_WAIT: if (tmr_done) next_s.st = ST_TD_START;
      ST_ACTIVE: if (rf_link_err) begin
        send = 1'b1;
        if (pay) begin
          skind = NTF_DEACT;
          sstat = LINK_LOSS_REASON;
          next_s.ph = PH_OFF;
          next_s.st = ST_CMD;
        end else begin
          skind = NTF_INTF_ERR;
        end
      end
      ST_NTF: if (ntf_ready) begin
        next_s.ntf_valid = 1'b0;
        next_s.st = s.ret;
      end
    endcase
    // host deactivation to idle overrides everything in flight
    if (host_deact_req) begin
      send = 1'b0;
      next_s.st = ST_IDLE;
      next_s.cmd_valid = 1'b0;
      next_s.ntf_valid = 1'b0;
    end
    // queue one notice; the sequencer resumes where it was headed
    if (send) begin
      next_s.ret = next_s.st;
      next_s.st = ST_NTF;
      next_s.ntf_valid = 1'b1;
      next_s.kind = skind;
      next_s.nstat = sstat;
      next_s.payload = spay;
      next_s.gid = (skind == NTF_TRACE) ? TRACE_GID : 4'h0;
      next_s.oid = (skind == NTF_TRACE) ? TRACE_OID : 8'h00;
    end
    // command issue on entry to the command state
    if (next_s.st == ST_CMD && s.st != ST_CMD) begin
      next_s.cmd_valid = 1'b1;
      next_s.ctech = next_s.tech;
      unique case (next_s.ph)
        PH_WUP: next_s.op = pay ? OP_WUP : OP_REQ;
        PH_ACT: next_s.op = OP_ACT;
        PH_HALT: next_s.op = OP_HALT;
        PH_OTHER: begin
          next_s.op = OP_WUP;
          next_s.ctech = next_s.tech ^ 2'h1;
        end
        PH_REACT: next_s.op = OP_REACT;
        PH_ISODEP: next_s.op = OP_ISODEP;
        PH_OFF: next_s.op = OP_FIELD_OFF;
        PH_PULSE: next_s.op = OP_DET_PULSE;
      endcase
    end
    // wait timer starts on entry; detection waits use retry spacing with detector on
    if (next_s.st != s.st &&
        (next_s.st == ST_LP_WAIT || next_s.st == ST_TD_WAIT)) begin
      next_s.tmr_start = 1'b1;
      next_s.tmr_units = (next_s.st == ST_LP_WAIT || !s.det_en) ?
                         s.dperiod : s.rperiod;
    end
  end

  // state register, frozen while ce is low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.tech_en <= RST_TECH_EN;
      s.profile <= RST_PROFILE;
      s.rperiod <= RST_RETRY_PERIOD;
      s.rcount <= RST_RETRY_COUNT;
      s.dperiod <= RST_DISC_PERIOD;
      s.thresh <= RST_THRESH;
    end else if (ce) begin
      s <= next_s;
    end
  end

  // outputs
  assign pready = ce;
  assign prdata = s.prdata;
  assign pslverr = s.slverr;
  assign rf_cmd_valid = s.cmd_valid;
  assign rf_cmd_op = s.op;
  assign rf_cmd_tech = s.ctech;
  assign ntf_valid = s.ntf_valid;
  assign ntf_kind = s.kind;
  assign ntf_gid = s.gid;
  assign ntf_oid = s.oid;
  assign ntf_status = s.nstat;
  assign ntf_payload = s.payload;

  // ============================================================
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn || !ce);
  wire trig_c = ((meas_value >= {1'b0, ref_value[14:0]}) ?
    meas_value - {1'b0, ref_value[14:0]} :
    {1'b0, ref_value[14:0]} - meas_value) > s.thresh;
  wire chk_trig = s.st == ST_MEAS && meas_valid && trig_c && !host_deact_req;
  AST_TRIG_START: assert property (chk_trig && !s.trace_en |=>
    s.st == ST_TD_START) else $error("trigger did not start detection");
  AST_RELOAD: assert property (chk_trig |=> s.retries == $past(s.rcount))
    else $error("retry counter not reloaded");
  AST_RETRY_END: assert property (s.st == ST_END && s.det_en &&
    s.retries == 8'h00 && !host_deact_req |=> s.st == ST_LP_WAIT ##1
    s.tmr_units == s.dperiod) else $error("retries exhausted, no return");
  AST_NO_PULSE: assert property (s.cmd_valid && s.op == OP_DET_PULSE |->
    s.det_en || $past(s.det_en, 2)) else $error("pulse with detector off");
  AST_TRACE_HDR: assert property (s.ntf_valid && s.kind == NTF_TRACE |->
    s.gid == 4'hF && s.oid == 8'h13 && !s.payload[TRACE_RSVD_BIT])
    else $error("bad trace notice header");
  AST_TRACE_MEAS: assert property ($rose(s.ntf_valid) &&
    s.kind == NTF_TRACE |-> s.payload[31:16] == $past(meas_value))
    else $error("trace measurement wrong");
  AST_PAY_WUP: assert property (s.cmd_valid && s.profile == PAY_PROFILE &&
    s.ph == PH_WUP |-> s.op == OP_WUP && s.ctech <= TECH_B)
    else $error("payment poll not WUPA or WUPB");
  AST_COLL: assert property (s.st == ST_RSP && rf_rsp_valid &&
    s.profile == PAY_PROFILE && s.ph == PH_WUP && rf_rsp == RSP_COLL &&
    !host_deact_req |=> s.ntf_valid && s.nstat == COLLISION_STATUS ##0
    s.ret == ST_END) else $error("collision not reported");
  AST_HALT_SEEK: assert property (s.st == ST_RSP && rf_rsp_valid &&
    s.ph == PH_HALT && !host_deact_req |=> s.cmd_valid && s.op == OP_WUP &&
    s.ctech == (s.tech ^ 2'h1)) else $error("no search after halt");
  AST_ACT_ONE: assert property ($rose(s.ntf_valid) &&
    s.kind == NTF_INTF_ACT |-> $past(s.ph) == PH_ISODEP)
    else $error("activation without single card");
  AST_LINK_LOSS: assert property (s.st == ST_ACTIVE && rf_link_err &&
    s.profile == PAY_PROFILE && !host_deact_req |=> s.kind == NTF_DEACT
    && s.ret == ST_CMD && s.ph == PH_OFF) else $error("no link loss path");
  AST_FORUM_ERR: assert property (s.st == ST_ACTIVE && rf_link_err &&
    s.profile != PAY_PROFILE && !host_deact_req |=> s.kind == NTF_INTF_ERR
    && s.ret == ST_ACTIVE) else $error("no interface error");
  COV_ACT: cover property (s.ntf_valid && s.kind == NTF_INTF_ACT);
  COV_COLL: cover property (s.ntf_valid && s.nstat == COLLISION_STATUS);
  COV_LOSS: cover property (s.ntf_valid && s.kind == NTF_DEACT);
  COV_TRACE: cover property (s.ntf_valid && s.kind == NTF_TRACE);
endmodule : cdd_discovery_ctrl

// ---- pkg/cdd_pkg.sv ----
// cdd_pkg: constants, enumerations and register map of the discovery control
// assumes one 20 MHz pclk domain and register access over APB
// ============================================================
// package body
package cdd_pkg;
  // timing
  localparam int CLK_HZ = 20_000_000;
  localparam int RETRY_UNIT_MS = 10;
  localparam int RETRY_UNIT_CYCLES = RETRY_UNIT_MS * (CLK_HZ / 1000);
  // register offsets (byte addresses)
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PROFILE = 8'h04;
  localparam logic [7:0] OFS_RETRY = 8'h08;
  localparam logic [7:0] OFS_DISC = 8'h0C;
  localparam logic [7:0] OFS_THRESH = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  // field positions
  localparam int CTRL_START = 0;
  localparam int CTRL_DET = 1;
  localparam int CTRL_TRACE = 2;
  localparam int CTRL_TECH = 3;
  localparam int RETRY_PERIOD_LSB = 0;
  localparam int RETRY_COUNT_LSB = 8;
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_RETRY_LSB = 8;
  localparam int STAT_CMD = 16;
  localparam int STAT_NTF = 17;
  localparam int TRACE_RSVD_BIT = 15;
  // values after reset
  localparam logic [2:0] RST_TECH_EN = 3'h7;
  localparam logic [7:0] RST_PROFILE = 8'h00;
  localparam logic [7:0] RST_RETRY_PERIOD = 8'h05;
  localparam logic [7:0] RST_RETRY_COUNT = 8'h03;
  localparam logic [7:0] RST_DISC_PERIOD = 8'h1E;
  localparam logic [15:0] RST_THRESH = 16'h0010;
  // codes
  localparam logic [7:0] PAY_PROFILE = 8'h01;
  localparam logic [3:0] TRACE_GID = 4'hF;
  localparam logic [7:0] TRACE_OID = 8'h13;
  localparam logic [1:0] TECH_A = 2'h0;
  localparam logic [1:0] TECH_B = 2'h1;
  // ============================================================
  // enumerations
  typedef enum logic [3:0] {
    ST_IDLE, ST_LP_WAIT, ST_MEAS, ST_TD_START, ST_CMD, ST_RSP, ST_END,
    ST_TD_WAIT, ST_ACTIVE, ST_NTF
  } cdd_state_e;
  typedef enum logic [2:0] {
    PH_WUP, PH_ACT, PH_HALT, PH_OTHER, PH_REACT, PH_ISODEP, PH_OFF, PH_PULSE
  } cdd_phase_e;
  typedef enum logic [2:0] {
    OP_REQ, OP_WUP, OP_ACT, OP_HALT, OP_REACT, OP_ISODEP, OP_FIELD_OFF,
    OP_DET_PULSE
  } cdd_op_e;
  typedef enum logic [2:0] {
    RSP_NONE, RSP_CARD, RSP_COLL, RSP_OK, RSP_FAIL
  } cdd_rsp_e;
  typedef enum logic [2:0] {
    NTF_NONE, NTF_TRACE, NTF_GEN_ERR, NTF_INTF_ERR, NTF_INTF_ACT, NTF_DEACT
  } cdd_ntf_e;
endpackage : cdd_pkg

// ---- src/cdd_tick_timer.sv ----
// cdd_tick_timer: counts a number of 10 ms steps and pulses done at the end
// assumes start is a one-cycle pulse from the discovery control on pclk
module cdd_tick_timer #(
  parameter int TICK_CYCLES = cdd_pkg::RETRY_UNIT_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic start,
  input wire logic [7:0] units,
  output logic done
);
  import cdd_pkg::*;
  typedef struct packed {
    logic run;
    logic done;
    logic [7:0] left;
    logic [23:0] cyc;
  } cdd_tmr_s;
  cdd_tmr_s s;
  cdd_tmr_s next_s;
  localparam logic [23:0] LAST = 24'(TICK_CYCLES - 1);

  // ============================================================
  // step counter; a zero count ends at once so a zero period never hangs
  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    if (start) begin
      next_s.run = (units != 8'h00);
      next_s.done = (units == 8'h00);
      next_s.left = units;
      next_s.cyc = 24'h000000;
    end else if (s.run) begin
      if (s.cyc == LAST) begin
        next_s.cyc = 24'h000000;
        next_s.left = s.left - 8'h01;
        if (s.left == 8'h01) begin
          next_s.run = 1'b0;
          next_s.done = 1'b1;
        end
      end else begin
        next_s.cyc = s.cyc + 24'h000001;
      end
    end
  end

  // state register, frozen while ce is low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign done = s.done;
endmodule : cdd_tick_timer

// ---- verification/cdd_rf_model.sv ----
// cdd_rf_model: behavioural RF front end and field detector
// assumes commands from cdd_discovery_ctrl on pclk
module cdd_rf_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [1:0] mode,
  input wire logic rf_cmd_valid,
  input wire cdd_pkg::cdd_op_e rf_cmd_op,
  input wire logic [1:0] rf_cmd_tech,
  output logic rf_cmd_ready,
  output logic rf_rsp_valid,
  output cdd_pkg::cdd_rsp_e rf_rsp,
  output logic meas_valid,
  output logic [15:0] meas_value,
  output logic [15:0] ref_value
);
  import cdd_pkg::*;
  cdd_op_e op;
  logic [1:0] tech;
  int dly;
  // reserved top bit set on purpose, it must not reach the notice
  assign ref_value = 16'h8123;
  // ============================================================
  // answers: mode 0 empty field, 1 one A card, 2 collision, 3 bad card
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dly <= 0;
      rf_cmd_ready <= 1'b0;
      rf_rsp_valid <= 1'b0;
      meas_valid <= 1'b0;
      op <= OP_REQ;
    end else begin
      rf_cmd_ready <= 1'($urandom_range(0, 1)); // random stalls
      rf_rsp_valid <= 1'b0;
      meas_valid <= 1'b0;
      rf_rsp <= cdd_rsp_e'($urandom_range(0, 7)); // noise between answers
      meas_value <= 16'($urandom);
      if (rf_cmd_valid && rf_cmd_ready) begin
        op <= rf_cmd_op;
        tech <= rf_cmd_tech;
        dly <= $urandom_range(2, 6);
      end else if (dly > 1) begin
        dly <= dly - 1;
      end else if (dly == 1) begin
        dly <= 0;
        // field off and detector pulse get no command answer
        rf_rsp_valid <= (op != OP_FIELD_OFF) && (op != OP_DET_PULSE);
        meas_valid <= (op == OP_DET_PULSE);
        meas_value <= 16'h0323; // far above the reset threshold
        case (op)
          OP_REQ, OP_WUP: begin
            if (mode == 2'h2) rf_rsp <= RSP_COLL;
            else if (mode != 2'h0 && tech == TECH_A) rf_rsp <= RSP_CARD;
            else rf_rsp <= RSP_NONE;
          end
          OP_HALT: rf_rsp <= RSP_OK;
          default: rf_rsp <= (mode == 2'h3) ? RSP_FAIL : RSP_OK;
        endcase
      end
    end
  end
endmodule : cdd_rf_model

// ---- verification/test_cdd_discovery_ctrl.sv ----
// test_cdd_discovery_ctrl: self-checking bench, notices checked from a queue
// assumes cdd_rf_model as RF front end and a 4-cycle time step
module test_cdd_discovery_ctrl;
  timeunit 1ns;
  timeprecision 1ns;
  import cdd_pkg::*;
  typedef struct packed {
    cdd_ntf_e kind;
    logic [7:0] status;
    logic [31:0] pay;
  } cdd_exp_s;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr, ntf_oid, ntf_status;
  logic [31:0] pwdata, prdata, ntf_payload, rd;
  logic [15:0] meas_value, ref_value;
  logic meas_valid, rf_cmd_valid, rf_cmd_ready, rf_rsp_valid, rf_link_err;
  logic host_deact_req, ntf_valid, ntf_ready, ntf_en, ce;
  logic [1:0] rf_cmd_tech, mode;
  logic [3:0] ntf_gid;
  cdd_op_e rf_cmd_op;
  cdd_rsp_e rf_rsp;
  cdd_ntf_e ntf_kind;
  int failures, compares;
  cdd_exp_s expq[$];
  cdd_exp_s e;
  // ============================================================
  // design and RF partner; clock enable low only around the first access
  cdd_discovery_ctrl #(.TICK_CYCLES(4)) u_cdd_discovery_ctrl (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .meas_valid(meas_valid), .meas_value(meas_value),
    .ref_value(ref_value), .rf_cmd_valid(rf_cmd_valid),
    .rf_cmd_op(rf_cmd_op), .rf_cmd_tech(rf_cmd_tech),
    .rf_cmd_ready(rf_cmd_ready), .rf_rsp_valid(rf_rsp_valid),
    .rf_rsp(rf_rsp), .rf_link_err(rf_link_err),
    .host_deact_req(host_deact_req), .ntf_valid(ntf_valid),
    .ntf_kind(ntf_kind), .ntf_gid(ntf_gid), .ntf_oid(ntf_oid),
    .ntf_status(ntf_status), .ntf_payload(ntf_payload),
    .ntf_ready(ntf_ready));
  cdd_rf_model u_cdd_rf_model (
    .pclk(pclk), .presetn(presetn), .mode(mode),
    .rf_cmd_valid(rf_cmd_valid), .rf_cmd_op(rf_cmd_op),
    .rf_cmd_tech(rf_cmd_tech), .rf_cmd_ready(rf_cmd_ready),
    .rf_rsp_valid(rf_rsp_valid), .rf_rsp(rf_rsp),
    .meas_valid(meas_valid), .meas_value(meas_value),
    .ref_value(ref_value));
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  // freeze the design in the first access phase to force wait states
  initial begin
    ce = 1'b1;
    repeat (22) @(posedge pclk);
    ce <= 1'b0;
    repeat (3) @(posedge pclk);
    ce <= 1'b1;
  end
  // ============================================================
  // helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one APB transfer, held until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic want(input cdd_ntf_e k, input logic [7:0] s,
                      input logic [31:0] p);
    expq.push_back('{k, s, p});
  endtask : want
  task automatic drain();
    int n;
    n = 0;
    while (expq.size() != 0 && n < 4000) begin
      @(posedge pclk);
      n++;
    end
    chk(32'(expq.size()), 32'h0);
  endtask : drain
  // host abort drops stale notices, then a fresh start
  task automatic restart(input logic [1:0] m, input logic [7:0] prof,
                         input logic [31:0] ctrl);
    ntf_en <= 1'b0;
    repeat (3) @(posedge pclk);
    host_deact_req <= 1'b1;
    @(posedge pclk);
    host_deact_req <= 1'b0;
    mode <= m;
    ntf_en <= 1'b1;
    apb(1'b1, OFS_PROFILE, 32'(prof));
    // start looks at the enables already held, so set them first
    apb(1'b1, OFS_CTRL, ctrl & 32'hFFFFFFFE);
    apb(1'b1, OFS_CTRL, ctrl);
  endtask : restart
  task automatic report_and_stop();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : report_and_stop
  // ============================================================
  // host side: random ready, notices compared oldest first
  always @(posedge pclk) begin
    ntf_ready <= ntf_en & 1'($urandom_range(0, 1));
    if (ntf_valid === 1'b1 && ntf_ready === 1'b1) begin
      e = (expq.size() != 0) ? expq.pop_front() :
          cdd_exp_s'{NTF_NONE, 8'h00, 32'h00000000};
      chk(32'(ntf_kind), 32'(e.kind));
      if (e.kind == NTF_TRACE) begin
        chk({ntf_gid, ntf_oid}, {TRACE_GID, TRACE_OID});
        chk(ntf_payload, e.pay);
      end else if (e.kind == NTF_GEN_ERR || e.kind == NTF_DEACT) begin
        chk(32'(ntf_status), 32'(e.status));
      end
    end
  end
  initial begin
    repeat (60000) @(posedge pclk);
    failures++;
    report_and_stop();
  end
  // ============================================================
  // main sequence
  initial begin
    void'($urandom(43391));
    {presetn, psel, penable, pwrite, rf_link_err, host_deact_req} = 6'h0;
    {ntf_en, ntf_ready, mode, paddr, pwdata} = '0;
    failures = 0;
    compares = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, OFS_RETRY, 32'h0);
    chk(rd, {16'h0, RST_RETRY_COUNT, RST_RETRY_PERIOD});
    apb(1'b0, 8'h18, 32'h0);
    chk({rd[30:0], err}, 32'h1);
    apb(1'b1, OFS_DISC, 32'h1);
    // only poll A and B for the payment profile
    want(NTF_INTF_ACT, 8'h0, 32'h0);
    restart(2'h1, PAY_PROFILE, 32'h19);
    drain();
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(32'(rd[3:0]), 32'(ST_ACTIVE));
    // link loss, then colliding cards seen on every loop
    mode <= 2'h2;
    want(NTF_DEACT, 8'h03, 32'h0);
    want(NTF_GEN_ERR, 8'h01, 32'h0);
    want(NTF_GEN_ERR, 8'h01, 32'h0);
    rf_link_err <= 1'b1;
    @(posedge pclk);
    rf_link_err <= 1'b0;
    drain();
    want(NTF_GEN_ERR, 8'h02, 32'h0);
    restart(2'h3, PAY_PROFILE, 32'h19);
    drain();
    // forum profile keeps the link active after an error
    want(NTF_INTF_ACT, 8'h0, 32'h0);
    want(NTF_INTF_ERR, 8'h0, 32'h0);
    restart(2'h1, 8'h00, 32'h19);
    while (expq.size() > 1) @(posedge pclk);
    repeat (2) @(posedge pclk);
    rf_link_err <= 1'b1;
    @(posedge pclk);
    rf_link_err <= 1'b0;
    drain();
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(32'(rd[3:0]), 32'(ST_ACTIVE));
    // detector and trace on: measurement, then reference low 15 bits
    want(NTF_TRACE, 8'h0, 32'h0323_0123);
    restart(2'h0, PAY_PROFILE, 32'h1F);
    drain();
    ntf_en <= 1'b0;
    report_and_stop();
  end
endmodule : test_cdd_discovery_ctrl
